// >>> saf_params.svh
// Constants for the serial-frame converter control block
`ifndef SAF_PARAMS_SVH
`define SAF_PARAMS_SVH

// Counter and field sizes
`define SAF_CNT_W       4
`define SAF_CODE_STEPS  4096
`define SAF_CH_W        3
`define SAF_CTRL_W      8
`define SAF_CH_LSB      3
`define SAF_FIFO_DEPTH  16

// Counter values: rising edges already seen in a conversion
`define SAF_CNT_ZERO    4'h0
`define SAF_TRACK_END   4'h3
`define SAF_DATA_START  4'h4
`define SAF_CTRL_LAST   4'h7
`define SAF_DECIDE_LAST 4'he
`define SAF_CONV_LAST   4'hf

// Bases for bit index arithmetic
`define SAF_OUT_BASE    4'hf
`define SAF_TRIAL_BASE  4'he

`endif

// >>> saf_pkg.sv
// Types shared by the serial-frame converter control block
`default_nettype none

package saf_pkg;

  // Sampling switch state within one conversion
  typedef enum logic {
    saf_track,
    saf_hold
  } saf_phase_type;

endpackage : saf_pkg

`default_nettype wire

// >>> saf_fifo.sv
// Result FIFO with registered output stage
`default_nettype none

module saf_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];       // Storage array
  logic [PW-1:0]    wr_ptr;            // Write index
  logic [PW-1:0]    rd_ptr;            // Read index
  logic [CW-1:0]    count;             // Words in storage
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push;              // Word accepted
  logic             pop;               // Word moved to output

  // Pointer step with wrap at depth
  function automatic logic [PW-1:0] saf_step(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return PW'(p + 1'b1);
  endfunction : saf_step

  // Next state of storage pointers and output stage
  always_comb begin
    in_ready_out   = (count != CW'(DEPTH));
    push           = in_valid_in && in_ready_out;
    pop            = (count != '0) && (!out_valid_out || out_ready_in);
    next_wr_ptr    = push ? saf_step(wr_ptr) : wr_ptr;
    next_rd_ptr    = pop ? saf_step(rd_ptr) : rd_ptr;
    next_count     = CW'(count + CW'(push) - CW'(pop));
    next_out_data  = pop ? mem[rd_ptr] : out_data_out;
    next_out_valid = pop || (out_valid_out && !out_ready_in);
  end

  // Register pointers, output stage and storage
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else begin
      wr_ptr        <= next_wr_ptr;
      rd_ptr        <= next_rd_ptr;
      count         <= next_count;
      out_valid_out <= next_out_valid;
      out_data_out  <= next_out_data;
    end
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

endmodule : saf_fifo

`default_nettype wire

// >>> saf_frame.sv
// Frame sequencer, SAR search and serial readout of the converter
//
// Overview of operation
// R1: Track the selected input for three clocks
// R2: Hold and convert for thirteen clocks
// R3: Successive approximation sets the DAC word
// R4: Result is a straight binary 12-bit code
// R5: Host keeps conversion rate at least 50k
// R6: Chip select fall enables the data output
// R7: Chip select rise floats the data output
// R8: New output bit launched on falling edge
// R9: Data input sampled on rising edges
// R10: Host frames chip select around rising edges
// R11: Four zeros then twelve bits, MSB first
// R12: First eight rising edges load control word
// R13: Conversions repeat every sixteen rising edges
// R14: Host discards first conversion after power-up
// R15: Chip select high clears the edge counter
`include "saf_params.svh"
`default_nettype none

module saf_frame
  import saf_pkg::*;
#(
  parameter int FIFO_DEPTH = `SAF_FIFO_DEPTH
) (
  input  wire logic clock_in,          // System clock
  input  wire logic rst_in,            // System reset
  input  wire logic sclk_in,           // Serial clock from host
  input  wire logic cs_n_in,           // Chip select, active low
  input  wire logic din_in,            // Serial data input
  input  wire logic comparator_in,     // High when input above DAC
  output logic      dout_out,          // Serial data output level
  output logic      dout_oe_out,       // Serial output driven
  output logic      track_out,         // Sampling switch on input
  output logic [`SAF_CH_W-1:0] channel_out,   // Input mux select
  output logic [$clog2(`SAF_CODE_STEPS)-1:0] dac_word_out,
  output logic [`SAF_CH_W+$clog2(`SAF_CODE_STEPS)-1:0] result_data_out,
  output logic      result_valid_out,  // Result word available
  input  wire logic result_ready_in,   // Consumer takes result
  output logic      overflow_out       // A result was lost
);

  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int RES_W = $clog2(`SAF_CODE_STEPS);
  localparam int WRD_W = `SAF_CH_W + RES_W;

  // ----------------------------------------------------------
  // Link-side state, rising serial clock
  // ----------------------------------------------------------
  logic [`SAF_CNT_W-1:0]  rcnt;        // Rising edges in conversion
  logic [`SAF_CTRL_W-1:0] ctrl;        // Control word shifter
  logic [RES_W-1:0]       result;      // Decided result bits
  logic [`SAF_CNT_W-1:0]  next_rcnt;
  logic [`SAF_CTRL_W-1:0] next_ctrl;
  logic [RES_W-1:0]       next_result;

  // Link-side state kept across frames
  logic                   rst_meta;    // Reset synchroniser stage 1
  logic                   link_rst;    // Reset synchroniser stage 2
  logic [WRD_W-1:0]       xfer_word;   // Word handed to system side
  logic                   xfer_tgl;    // Flips once per result
  logic [`SAF_CH_W-1:0]   next_channel;
  logic [WRD_W-1:0]       next_xfer_word;
  logic                   next_xfer_tgl;

  // ----------------------------------------------------------
  // Link-side state, falling serial clock
  // ----------------------------------------------------------
  saf_phase_type          phase;       // Track or hold
  saf_phase_type          next_phase;
  logic                   next_track;
  logic                   next_dout;
  logic [RES_W-1:0]       next_dac;

  // ----------------------------------------------------------
  // System-side state
  // ----------------------------------------------------------
  logic                   tgl_meta;    // Toggle synchroniser stage 1
  logic                   tgl_sync;    // Toggle synchroniser stage 2
  logic                   tgl_seen;    // Last toggle value handled
  logic [WRD_W-1:0]       pend_word;   // Word waiting for FIFO
  logic                   pend_valid;  // Pending word present
  logic                   next_tgl_seen;
  logic [WRD_W-1:0]       next_pend_word;
  logic                   next_pend_valid;
  logic                   next_overflow;
  logic                   new_word;    // Fresh result arrived
  logic                   fifo_ready;  // FIFO can take a word
  logic                   take;        // Load pending register

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------

  // Bit position counted down from a base
  function automatic logic [`SAF_CNT_W-1:0] saf_index(
    input logic [`SAF_CNT_W-1:0] base,
    input logic [`SAF_CNT_W-1:0] cnt
  );
    return `SAF_CNT_W'(base - cnt);
  endfunction : saf_index

  // Mask of bits strictly above a position
  function automatic logic [RES_W-1:0] saf_above(
    input logic [`SAF_CNT_W-1:0] pos
  );
    logic [RES_W-1:0] m;
    m = '1;
    m = m << pos;
    m = m << 1;
    return m;
  endfunction : saf_above

  // Single bit at a position
  function automatic logic [RES_W-1:0] saf_onehot(
    input logic [`SAF_CNT_W-1:0] pos
  );
    logic [RES_W-1:0] m;
    m = {{(RES_W-1){1'b0}}, 1'b1};
    return m << pos;
  endfunction : saf_onehot

  // ----------------------------------------------------------
  // Rising-edge sequencer
  // ----------------------------------------------------------

  // Next edge count, control word and comparator decisions
  always_comb begin
    // Wraps every sixteen edges for back-to-back conversions
    next_rcnt   = `SAF_CNT_W'(rcnt + `SAF_CNT_W'(1));  // [R13] [R2]
    next_ctrl   = ctrl;
    next_result = result;
    // First eight edges shift the control word in
    if (rcnt <= `SAF_CTRL_LAST) begin
      next_ctrl = {ctrl[`SAF_CTRL_W-2:0], din_in};  // [R12] [R9]
    end
    // Keep the trial bit when the input is above the DAC
    if (rcnt >= `SAF_TRACK_END && rcnt <= `SAF_DECIDE_LAST) begin
      next_result[saf_index(`SAF_TRIAL_BASE, rcnt)] =
        comparator_in;                               // [R3] [R4]
    end
  end

  // Cleared and frozen while chip select is high
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      rcnt   <= `SAF_CNT_ZERO;                       // [R15]
      ctrl   <= '0;
      result <= '0;
    end else begin
      rcnt   <= next_rcnt;
      ctrl   <= next_ctrl;
      result <= next_result;
    end
  end

  // ----------------------------------------------------------
  // Channel select and result hand-off
  // ----------------------------------------------------------

  // Channel takes effect for the next conversion
  always_comb begin
    next_channel   = channel_out;
    next_xfer_word = xfer_word;
    next_xfer_tgl  = xfer_tgl;
    // Sixteenth edge closes the conversion
    if (rcnt == `SAF_CONV_LAST && !cs_n_in) begin
      next_channel   = ctrl[`SAF_CH_LSB +: `SAF_CH_W];  // [R12]
      next_xfer_word = {channel_out, result};
      next_xfer_tgl  = !xfer_tgl;
    end
  end

  // Survives chip select; reset reaches it only while clocking
  always_ff @(posedge sclk_in) begin
    rst_meta <= rst_in;
    link_rst <= rst_meta;
    if (link_rst) begin
      channel_out <= '0;
      xfer_word   <= '0;
      xfer_tgl    <= 1'b0;
    end else begin
      channel_out <= next_channel;
      xfer_word   <= next_xfer_word;
      xfer_tgl    <= next_xfer_tgl;
    end
  end

  // ----------------------------------------------------------
  // Falling-edge sequencer
  // ----------------------------------------------------------

  // Phase, output bit and DAC trial word
  always_comb begin
    next_phase = phase;
    next_dout  = 1'b0;
    next_dac   = dac_word_out;
    // Falling edge after the third rise starts hold
    if (rcnt == `SAF_TRACK_END) begin
      next_phase = saf_hold;                         // [R1] [R2]
    end else if (rcnt == `SAF_CNT_ZERO) begin
      next_phase = saf_track;                        // [R1] [R13]
    end
    // Leading zeros, then decided bits MSB first
    if (rcnt >= `SAF_DATA_START) begin
      next_dout = result[saf_index(`SAF_OUT_BASE, rcnt)];  // [R11]
    end
    // Kept bits above, trial bit at the current position
    if (rcnt >= `SAF_TRACK_END && rcnt <= `SAF_DECIDE_LAST) begin
      next_dac = (result & saf_above(saf_index(`SAF_TRIAL_BASE, rcnt)))
               | saf_onehot(saf_index(`SAF_TRIAL_BASE, rcnt));  // [R3]
    end
    next_track = (next_phase == saf_track);
  end

  // Launch on falling edges; previous bit stands until then
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      phase        <= saf_track;
      track_out    <= 1'b1;
      dout_out     <= 1'b0;
      dac_word_out <= '0;
    end else begin
      phase        <= next_phase;
      track_out    <= next_track;                    // [R1]
      dout_out     <= next_dout;                     // [R8]
      dac_word_out <= next_dac;
    end
  end

  // ----------------------------------------------------------
  // Output enable follows chip select
  // ----------------------------------------------------------

  // Set by the falling edge, cleared by the rising level
  always_ff @(negedge cs_n_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      dout_oe_out <= 1'b0;                           // [R7]
    end else begin
      dout_oe_out <= 1'b1;                           // [R6]
    end
  end

  // ----------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------

  // Pending word feeds the FIFO; overflow when it cannot drain
  always_comb begin
    new_word        = tgl_sync ^ tgl_seen;
    take            = new_word && (!pend_valid || fifo_ready);
    next_tgl_seen   = tgl_sync;
    next_pend_word  = take ? xfer_word : pend_word;
    next_pend_valid = take || (pend_valid && !fifo_ready);
    // Sticky until reset
    next_overflow   = overflow_out || (new_word && !take);
  end

  // Toggle synchroniser and pending register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tgl_meta     <= 1'b0;
      tgl_sync     <= 1'b0;
      tgl_seen     <= 1'b0;
      pend_word    <= '0;
      pend_valid   <= 1'b0;
      overflow_out <= 1'b0;
    end else begin
      tgl_meta     <= xfer_tgl;
      tgl_sync     <= tgl_meta;
      tgl_seen     <= next_tgl_seen;
      pend_word    <= next_pend_word;
      pend_valid   <= next_pend_valid;
      overflow_out <= next_overflow;
    end
  end

  // ----------------------------------------------------------
  // Result FIFO
  // ----------------------------------------------------------

  // Holds channel and code pairs for the consumer
  saf_fifo #(
    .WIDTH (WRD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .in_valid_in   (pend_valid),
    .in_ready_out  (fifo_ready),
    .in_data_in    (pend_word),
    .out_valid_out (result_valid_out),
    .out_ready_in  (result_ready_in),
    .out_data_out  (result_data_out)
  );

endmodule : saf_frame

`default_nettype wire

// >>> saf_frame_asserts.sv
// Checker for frame timing and the result stream
`default_nettype none

module saf_frame_asserts (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        sclk_in,
  input wire logic        cs_n_in,
  input wire logic        din_in,
  input wire logic        comparator_in,
  input wire logic        dout_out,
  input wire logic        dout_oe_out,
  input wire logic        track_out,
  input wire logic [2:0]  channel_out,
  input wire logic [11:0] dac_word_out,
  input wire logic [14:0] result_data_out,
  input wire logic        result_valid_out,
  input wire logic        result_ready_in,
  input wire logic        overflow_out
);
  // ---
  // Helper logic
  // ---
  logic [3:0] cnt, next_cnt;  // Rising edges seen
  logic [7:0] ctl, next_ctl;  // Control word
  logic [2:0] sel, next_sel;  // Channel last loaded
  logic [3:0] tbit;           // Trial bit index
  // Next values
  always_comb begin
    next_cnt = cnt + 4'h1;
    next_ctl = (cnt < 4'h8) ? {ctl[6:0], din_in} : ctl;
    next_sel = rst_in ? 3'h0 : (cnt == 4'hf) ? ctl[5:3] : sel;
    tbit     = 4'he - cnt;
  end
  // Chip select high clears the count
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt <= 4'h0;
      ctl <= 8'h0;
    end else begin
      cnt <= next_cnt;
      ctl <= next_ctl;
    end
  end
  always_ff @(posedge sclk_in) begin
    sel <= next_sel;
  end
  // ---
  // Properties
  // ---
  sequence s_lead;
    cnt < 4'h4;
  endsequence
  sequence s_done;
    cnt == 4'hf;
  endsequence
  property p_oe;
    @(posedge clock_in) disable iff (rst_in) dout_oe_out == !cs_n_in;
  endproperty
  a_oe: assert property (p_oe)
    else $error("output enable not following select");
  property p_idle;
    @(posedge clock_in) disable iff (rst_in)
      cs_n_in |-> track_out && !dout_out && dac_word_out == 12'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle outputs wrong");
  property p_track;
    @(posedge sclk_in) disable iff (cs_n_in) track_out == (cnt < 4'h3);
  endproperty
  a_track: assert property (p_track)
    else $error("track window wrong");
  property p_zero;
    @(posedge sclk_in) disable iff (cs_n_in) s_lead |-> !dout_out;
  endproperty
  a_zero: assert property (p_zero)
    else $error("leading bit not zero");
  property p_bit;
    @(posedge sclk_in) disable iff (cs_n_in)
      cnt >= 4'h4 |-> dout_out == $past(comparator_in);
  endproperty
  a_bit: assert property (p_bit)
    else $error("output bit not the decision");
  property p_trial;
    @(posedge sclk_in) disable iff (cs_n_in)
      (cnt >= 4'h3 && cnt <= 4'he) |-> dac_word_out[tbit] &&
      (dac_word_out & (12'hfff >> (4'hc - tbit))) == 12'h0;
  endproperty
  a_trial: assert property (p_trial)
    else $error("trial word wrong");
  property p_chan;
    @(posedge sclk_in) disable iff (rst_in)
      s_done |=> channel_out == sel;
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel not loaded");
  property p_hold;
    @(posedge clock_in) disable iff (rst_in)
      result_valid_out && !result_ready_in |=>
      result_valid_out && $stable(result_data_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result dropped while waiting");
endmodule : saf_frame_asserts

bind saf_frame saf_frame_asserts i_chk (
  .clock_in(clock_in), .rst_in(rst_in), .sclk_in(sclk_in),
  .cs_n_in(cs_n_in), .din_in(din_in), .comparator_in(comparator_in),
  .dout_out(dout_out), .dout_oe_out(dout_oe_out),
  .track_out(track_out), .channel_out(channel_out),
  .dac_word_out(dac_word_out), .result_data_out(result_data_out),
  .result_valid_out(result_valid_out),
  .result_ready_in(result_ready_in), .overflow_out(overflow_out));

`default_nettype wire

// >>> saf_host_model.sv
// Host model: frames the link and plays the analog inputs
`default_nettype none

module saf_host_model (
  output logic             sclk_out,        // Idle low
  output logic             cs_n_out,        // Active low
  output logic             din_out,         // Control bits
  output logic             comparator_out,  // Held level >= trial
  input  wire logic        dout_in,
  input  wire logic        track_in,
  input  wire logic [2:0]  channel_in,
  input  wire logic [11:0] dac_word_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] level [8];   // Analog level per input
  logic [11:0] held;        // Sampled level
  logic [7:0]  ctl [24];    // Control word per conversion
  logic [15:0] rx [24];     // Word read per conversion
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
    for (int c = 0; c < 8; c++) level[c] = {c[2:0], 9'h15a};
    level[0] = 12'hfff;     // Full scale
    level[7] = 12'h000;     // Zero scale
  end
  // Sample while tracking, then compare
  always @(*) if (track_in === 1'b1) held = level[channel_in];
  always_comb begin
    comparator_out = held >= dac_word_in;
  end
  // One frame of nrise rising edges
  task automatic frame(input int nrise);
    int k;
    #1.3 cs_n_out = 1'b0;   // Before first rise
    for (int i = 0; i < nrise; i++) begin
      k = i / 16;
      if (i % 16 < 8) din_out = ctl[k][7 - i % 16];
      else din_out = ~din_out;  // Ignored slots keep moving
      #15 sclk_out = 1'b1;      // 30 ns period
      rx[k] = {rx[k][14:0], dout_in};
      #15 sclk_out = 1'b0;
    end
    #15 cs_n_out = 1'b1;    // After last rise
    din_out = ~din_out;
  endtask : frame
endmodule : saf_host_model

`default_nettype wire

// >>> test_saf_frame.sv
// Testbench: frames, result stream and buffer overflow
`default_nettype none

module test_saf_frame;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_in, rst_in, ready;
  logic        sclk, cs_n, din, cmp, dout, oe, trk, valid, ovf;
  logic [2:0]  chan, cur_ch;
  logic [11:0] dac;
  logic [14:0] data;
  logic [14:0] got_q[$], exp_q[$];
  int          n_mismatch = 0, compares = 0;
  saf_frame i_saf_frame (.clock_in(clock_in), .rst_in(rst_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .comparator_in(cmp),
    .dout_out(dout), .dout_oe_out(oe), .track_out(trk),
    .channel_out(chan), .dac_word_out(dac), .result_data_out(data),
    .result_valid_out(valid), .result_ready_in(ready),
    .overflow_out(ovf));
  saf_host_model i_saf_host_model (.sclk_out(sclk), .cs_n_out(cs_n),
    .din_out(din), .comparator_out(cmp), .dout_in(dout),
    .track_in(trk), .channel_in(chan), .dac_word_in(dac));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // Collect accepted results
  always @(posedge clock_in) begin
    if (rst_in === 1'b0 && valid === 1'b1 && ready === 1'b1)
      got_q.push_back(data);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Frame of n conversions, channels counting up from first
  task automatic conv_frame(input int n, input logic [2:0] first);
    for (int k = 0; k < n; k++)
      i_saf_host_model.ctl[k] = 8'hc7 | {2'h0, 3'(first + k), 3'h0};
    i_saf_host_model.frame(16 * n);
    for (int k = 0; k < n; k++) begin
      chk(i_saf_host_model.rx[k],
          {4'h0, i_saf_host_model.level[cur_ch]});
      exp_q.push_back({cur_ch, i_saf_host_model.level[cur_ch]});
      cur_ch = 3'(first + k);
    end
    @(negedge clock_in);
  endtask : conv_frame
  task automatic drain(input int n);
    int t;
    t = 0;
    while (got_q.size() < n && t < 400) begin
      @(negedge clock_in);
      t++;
    end
    if (got_q.size() < n) begin
      n_mismatch++;
      $display("mismatch at %0t: results missing", $time);
      end_of_test();
    end
    repeat (8) @(negedge clock_in);
    chk(16'(got_q.size()), 16'(n));
    while (got_q.size() > 0)
      chk({1'b0, got_q.pop_front()}, {1'b0, exp_q.pop_front()});
  endtask : drain
  task automatic t_reset();
    i_saf_host_model.frame(3);  // Partial frame under reset
    repeat (8) @(negedge clock_in);
    rst_in = 1'b0;
    cur_ch = 3'h0;
    repeat (40) @(negedge clock_in);
    chk({15'h0, valid}, 16'h0);
    chk({13'h0, chan}, 16'h0);
    chk({15'h0, oe}, 16'h0);
    chk({15'h0, trk}, 16'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_stream();
    conv_frame(1, 3'h3);        // Dummy conversion first
    conv_frame(8, 3'h4);        // All eight channels
    i_saf_host_model.frame(10); // Aborted frame
    drain(9);
    $display("test stream done");
  endtask : t_stream
  task automatic t_fifo();
    ready = 1'b0;
    conv_frame(18, 3'h2);
    repeat (8) @(negedge clock_in);
    chk({15'h0, ovf}, 16'h0);
    conv_frame(1, 3'h5);
    repeat (8) @(negedge clock_in);
    chk({15'h0, ovf}, 16'h1);
    void'(exp_q.pop_back());    // Newest word is lost
    ready = 1'b1;
    drain(18);
    $display("test fifo done");
  endtask : t_fifo
  initial begin
    rst_in = 1'b1;
    ready  = 1'b1;
    t_reset();
    t_stream();
    t_fifo();
    end_of_test();
  end
endmodule : test_saf_frame

`default_nettype wire
